// *** hw/sfp_port.sv ***
`timescale 1ns/100ps
// Summary of operation
// [R1] Each command is one 16-bit serial word
// [R2] Frame starts on select falling edge
// [R3] Decode captured word only at select rise
// [R4] Release data output on select rise
// [R5] Sample input on falling serial clock edges
// [R6] Shift response out after rising clock edges
// [R7] No pass-through, no daisy chaining
// [R8] Discard unless 0 or 16 clocks, clock low
// [R9] Rejected frame flags error bit next frame
// [R10] Address bits 6..0, bit 7 write, data 15..8
// [R11] Ignore frames during restart state; the code only suppresses the command, the error flag still updates
// [R12] Clear counter and shifter at frame start
module sfp_port
    import sfp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic select_low_input_n_i,
    input wire logic mosi_i,
    input wire logic restart_state_i,
    input wire logic [FRAME_BITS-1:0] resp_word_i,
    output logic miso_o,
    output logic miso_oe_o,
    output logic cmd_valid_o,
    output sfp_cmd_t cmd_o,
    output logic frame_err_o
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------
    // High when a sampled pin went from low to high
    function automatic logic went_high(input logic prev_lvl, input logic now_lvl);
        return !prev_lvl && now_lvl;
    endfunction

    // High when a sampled pin went from high to low
    function automatic logic went_low(input logic prev_lvl, input logic now_lvl);
        return prev_lvl && !now_lvl;
    endfunction

    // Only an empty frame or a full word counts as well formed
    function automatic logic count_ok(input logic [CNT_W-1:0] cnt);
        return (cnt == CNT_NONE) || (cnt == CNT_FULL);
    endfunction

    // First bit out carries the error flag on top of the response
    function automatic logic [FRAME_BITS-1:0] load_word(input logic err,
                                                        input logic [FRAME_BITS-1:0] resp);
        return {err | resp[FRAME_BITS-1], resp[FRAME_BITS-2:0]};
    endfunction

    // Split a received word into address, direction and data byte
    function automatic sfp_cmd_t decode_cmd(input logic [FRAME_BITS-1:0] word);
        sfp_cmd_t cmd;
        cmd.addr = word[ADDR_LSB +: ADDR_W];
        cmd.write = word[WR_BIT];
        cmd.data = word[DATA_LSB +: DATA_W];
        return cmd;
    endfunction

    // ----------------------------------------------------------------
    // Pin history and edge detection
    // ----------------------------------------------------------------
    sfp_pins_t pins_now;
    sfp_pins_t pins_reg;
    logic sel_fall;
    logic sel_rise;
    logic sclk_fall;
    logic sclk_rise;
    sfp_state_t state_reg;

    assign pins_now = '{sclk: sclk_i, sel_n: select_low_input_n_i, mosi: mosi_i};

    // Previous pin levels
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pins_reg <= '{sclk: 1'b0, sel_n: 1'b1, mosi: 1'b0};
        end else begin
            pins_reg <= pins_now;
        end
    end

    // Select edges at any time, clock edges only while a frame is open
    assign sel_fall = went_low(pins_reg.sel_n, pins_now.sel_n); // [R2]
    assign sel_rise = went_high(pins_reg.sel_n, pins_now.sel_n);
    assign sclk_fall = (state_reg == SFP_BUSY) && went_low(pins_reg.sclk, pins_now.sclk);
    assign sclk_rise = (state_reg == SFP_BUSY) && went_high(pins_reg.sclk, pins_now.sclk);

    // ----------------------------------------------------------------
    // Frame state
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt_reg;
    logic [FRAME_BITS-1:0] rx_reg;
    logic [FRAME_BITS-1:0] tx_reg;
    logic clk_bad_reg;
    logic err_reg;
    logic frame_ok;
    logic frame_end;
    logic rise_clk_hi;

    // Idle until select falls, busy until it rises
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= SFP_IDLE;
        end else begin
            case (state_reg)
                SFP_IDLE: begin
                    if (sel_fall) begin
                        state_reg <= SFP_BUSY; // [R2]
                    end
                end
                SFP_BUSY: begin
                    if (sel_rise) begin
                        state_reg <= SFP_IDLE;
                    end
                end
                default: begin
                    state_reg <= SFP_IDLE;
                end
            endcase
        end
    end

    // Clock counter, saturates above the full count
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= CNT_NONE;
        end else if (sel_fall) begin
            cnt_reg <= CNT_NONE; // [R12]
        end else if (sclk_fall && cnt_reg <= CNT_FULL) begin
            cnt_reg <= cnt_reg + 5'h01; // [R8]
        end
    end

    // Receive shifter, MSB first
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_reg <= WORD_RESET;
        end else if (sel_fall) begin
            rx_reg <= WORD_RESET; // [R12]
        end else if (sclk_fall) begin
            rx_reg <= {rx_reg[FRAME_BITS-2:0], pins_now.mosi}; // [R5] [R1]
        end
    end

    // Serial clock high at either select edge spoils the frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_bad_reg <= 1'b0;
        end else if (sel_fall) begin
            clk_bad_reg <= pins_now.sclk; // [R8]
        end else if (rise_clk_hi) begin
            clk_bad_reg <= 1'b1; // [R8]
        end
    end

    // Clock still high as select rises
    assign rise_clk_hi = sel_rise && pins_now.sclk; // [R8]
    // Good frame: clock low at both select edges and 0 or 16 falls counted
    assign frame_ok = !clk_bad_reg && !rise_clk_hi && count_ok(cnt_reg); // [R8]
    // Select rises on an open frame
    assign frame_end = sel_rise && (state_reg == SFP_BUSY); // [R3]

    // Error flag, reported in the following frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            err_reg <= 1'b0;
        end else if (frame_end) begin
            err_reg <= !frame_ok; // [R9]
        end
    end

    // ----------------------------------------------------------------
    // Transmit side
    // ----------------------------------------------------------------
    // Load response at frame start, error bit first, shift after rising edges
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_reg <= WORD_RESET;
        end else if (sel_fall) begin
            tx_reg <= load_word(err_reg, resp_word_i); // [R9]
        end else if (sclk_rise) begin
            tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0}; // [R6] [R7]
        end
    end

    // Output drives only while busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            miso_oe_o <= 1'b0;
        end else if (sel_rise) begin
            miso_oe_o <= 1'b0; // [R4]
        end else if (sel_fall) begin
            miso_oe_o <= 1'b1;
        end
    end

    // Line shows zero when released; the pad turns it to high impedance
    assign miso_o = miso_oe_o ? tx_reg[FRAME_BITS-1] : 1'b0;
    assign frame_err_o = err_reg;

    // ----------------------------------------------------------------
    // Command decode at frame end
    // ----------------------------------------------------------------
    // One-cycle strobe and held command after a good full frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_valid_o <= 1'b0;
            cmd_o <= '0;
        end else begin
            cmd_valid_o <= 1'b0;
            // Only a full word decodes; an empty frame just clears the error flag
            if (frame_end && frame_ok && cnt_reg == CNT_FULL
                && !restart_state_i) begin // [R3] [R8] [R11]
                cmd_valid_o <= 1'b1;
                cmd_o <= decode_cmd(rx_reg); // [R10]
            end
        end
    end

endmodule

// *** hw/sfp_pkg.sv ***
package sfp_pkg;

    // ----------------------------------------------------------------
    // Frame format
    // ----------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
    localparam logic [CNT_W-1:0] CNT_NONE = 5'h00;
    localparam int ADDR_LSB = 0;
    localparam int ADDR_W = 7;
    localparam int WR_BIT = 7;
    localparam int DATA_LSB = 8;
    localparam int DATA_W = 8;
    localparam logic [FRAME_BITS-1:0] WORD_RESET = 16'h0000;

    // Decoded command handed to the core after a good frame
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic write;
        logic [ADDR_W-1:0] addr;
    } sfp_cmd_t;

    // Serial pins as sampled from the master
    typedef struct packed {
        logic sclk;
        logic sel_n;
        logic mosi;
    } sfp_pins_t;

    // Port state
    typedef enum logic [1:0] {
        SFP_IDLE = 2'b01,
        SFP_BUSY = 2'b10
    } sfp_state_t;

endpackage

// *** test/sfp_port_assertions.sv ***
`timescale 1ns/100ps
module sfp_port_assertions
    import sfp_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk_i,
    input wire logic select_low_input_n_i,
    input wire logic mosi_i,
    input wire logic restart_state_i,
    input wire logic [FRAME_BITS-1:0] resp_word_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic cmd_valid_o,
    input wire sfp_cmd_t cmd_o,
    input wire logic frame_err_o
);
    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    wire logic s = select_low_input_n_i;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_OE_ON: assert property ($fell(s) |=> miso_oe_o)
        else $error("oe late");
    AST_OE_OFF: assert property ($rose(s) |=> !miso_oe_o)
        else $error("oe held");
    AST_IDLE: assert property (s && $past(s) |-> !miso_oe_o)
        else $error("oe idle");
    AST_SHIFT: assert property (
        miso_oe_o && $past(miso_oe_o) && $changed(miso_o)
        |-> $past(sclk_i) && !$past(sclk_i, 2))
        else $error("miso moved without clock rise");
    AST_LATE: assert property (cmd_valid_o |-> $past(s) && !$past(s, 2))
        else $error("cmd time");
    AST_RST: assert property ($rose(s) && restart_state_i |=> !cmd_valid_o)
        else $error("restart");
    AST_ERR: assert property ($fell(s) && frame_err_o |=> miso_o)
        else $error("err bit");
    AST_HOLD: assert property (!cmd_valid_o |-> $stable(cmd_o))
        else $error("cmd moved");
    // Main scenarios
    cover property (cmd_valid_o);
    cover property ($fell(s) && frame_err_o);
    cover property ($rose(s) && restart_state_i);
    cover property ($rose(s) && sclk_i);
endmodule

// *** test/sfp_master.sv ***
`timescale 1ns/100ps
module sfp_master (
    input wire logic clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic sel_n_o,
    output logic mosi_o
);
    // Idle bus: select high, clock low
    initial begin
        sclk_o = 1'b0;
        sel_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Frame of n clocks, MSB first; hi[0] clock high at select fall, hi[1] at select rise
    task automatic xfer(input logic [15:0] w, input int n, input logic [1:0] hi,
                        output logic [15:0] r);
        r = 16'h0000;
        @(negedge clk_i);
        sel_n_o = 1'b0;
        sclk_o = hi[0];
        repeat (2) @(negedge clk_i);
        for (int i = 0; i < n; i++) begin
            r = {r[14:0], miso_i};
            mosi_o = w[15-(i%16)];
            sclk_o = 1'b1;
            repeat (2) @(negedge clk_i);
            sclk_o = 1'b0;
            repeat (2) @(negedge clk_i);
        end
        if (n == 0) r = {15'h0000, miso_i};
        if (hi[1]) begin
            sclk_o = 1'b1;
            repeat (2) @(negedge clk_i);
        end
        sel_n_o = 1'b1;
        mosi_o = ~mosi_o;
        repeat (2) @(negedge clk_i);
        sclk_o = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask
endmodule

// *** test/sfp_port_test.sv ***
`timescale 1ns/100ps
module sfp_port_test;
    import sfp_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic rs = 1'b0;
    logic [1:0] hi = 2'b00;
    logic [15:0] resp = 16'h0000;
    logic sclk, sel_n, mosi, miso, oe, cv, ferr;
    sfp_cmd_t cmd, last;
    logic [15:0] w, r;
    int error_cnt = 0;
    int check_count = 0;
    int vcnt = 0;
    // Clock and command monitor
    always #4 clk_i = ~clk_i;
    always @(negedge clk_i) begin
        if (cv === 1'b1) begin
            vcnt++;
            last = cmd;
        end
    end
    sfp_master mst_u (.clk_i(clk_i), .miso_i(miso), .sclk_o(sclk), .sel_n_o(sel_n),
        .mosi_o(mosi));
    sfp_port dut_u (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .select_low_input_n_i(sel_n),
        .mosi_i(mosi), .restart_state_i(rs), .resp_word_i(resp), .miso_o(miso),
        .miso_oe_o(oe), .cmd_valid_o(cv), .cmd_o(cmd), .frame_err_o(ferr));
    // Compare and report
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (e !== g) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    function logic [15:0] exp_resp(input logic [15:0] d, input logic e);
        return {d[15] | e, d[14:0]};
    endfunction
    function logic [15:0] exp_cmd(input logic [15:0] d);
        sfp_cmd_t c;
        c.addr = d[6:0];
        c.write = d[7];
        c.data = d[15:8];
        return c;
    endfunction
    task wrap_up;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // One frame and its checks
    task frame(input int n, input int nv);
        int v0;
        logic e;
        logic bad;
        v0 = vcnt;
        e = ferr;
        bad = (n != 0 && n != 16) || hi != 2'b00;
        w = 16'($urandom);
        resp = 16'($urandom);
        mst_u.xfer(w, n, hi, r);
        if (n == 16 && !hi[0]) chk("resp", exp_resp(resp, e), r);
        if (n == 0) chk("err bit", {15'h0000, e | resp[15]}, r);
        chk("cmds", 16'(nv), 16'(vcnt - v0));
        if (nv == 1) chk("cmd", exp_cmd(w), last);
        chk("err", {15'h0000, bad}, {15'h0000, ferr});
        chk("oe", 16'h0000, {15'h0000, oe});
    endtask
    // Main sequence
    initial begin
        void'($urandom(79));
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        for (int i = 0; i < 6; i++) frame(16, 1);
        $display("test random done");
        frame(5, 0);
        frame(16, 1);
        frame(17, 0);
        frame(0, 0);
        frame(0, 0);
        frame(16, 1);
        hi = 2'b01;
        frame(16, 0);
        hi = 2'b10;
        frame(16, 0);
        hi = 2'b00;
        frame(16, 1);
        $display("test count done");
        rs = 1'b1;
        frame(16, 0);
        rs = 1'b0;
        frame(16, 1);
        $display("test restart done");
        frame(5, 0);
        rst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        rst_i = 1'b0;
        chk("err rst", 16'h0000, {15'h0000, ferr});
        chk("cmd rst", 16'h0000, cmd);
        repeat (2) @(negedge clk_i);
        frame(16, 1);
        $display("test reset done");
        wrap_up();
    end
    // Hang guard
    initial begin
        #100000;
        error_cnt++;
        wrap_up();
    end
endmodule
bind sfp_port sfp_port_assertions chk_u (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .sclk_i(sclk_i),
    .select_low_input_n_i(select_low_input_n_i),
    .mosi_i(mosi_i),
    .restart_state_i(restart_state_i),
    .resp_word_i(resp_word_i),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o),
    .cmd_valid_o(cmd_valid_o),
    .cmd_o(cmd_o),
    .frame_err_o(frame_err_o)
);
